// ---- rtl/ddpm_pkg.sv ----
// package for the dual data pointer mode block
// assumes a single pclk domain and an apb register port
`default_nettype none
package ddpm_pkg;
    // register byte addresses; the limit register is given by its index
    localparam logic [9:0] ddpm_off_mode = 10'h0a0;
    localparam logic [9:0] ddpm_off_cfg = 10'h0a4;
    localparam logic [9:0] ddpm_off_dp0 = 10'h0a8;
    localparam logic [9:0] ddpm_off_dp1 = 10'h0ac;
    localparam logic [7:0] ddpm_off_last = 8'he3;
    // limit register byte address: four times its index
    localparam logic [9:0] ddpm_off_last_w = {ddpm_off_last, 2'b00};
    // pointer_mode_reg bit positions
    localparam int ddpm_bit_redirect = 0;
    localparam int ddpm_bit_movcdis = 1;
    localparam int ddpm_bit_circ0 = 2;
    localparam int ddpm_bit_circ1 = 3;
    // configuration bit positions
    localparam int ddpm_bit_sel = 0;
    localparam int ddpm_bit_down0 = 4;
    localparam int ddpm_bit_down1 = 5;
    localparam int ddpm_bit_upd0 = 6;
    localparam int ddpm_bit_upd1 = 7;
    // reset values
    localparam logic [7:0] ddpm_rst_mode = 8'h00;
    localparam logic [7:0] ddpm_rst_cfg = 8'h00;
    localparam logic [7:0] ddpm_rst_last = 8'h00;
    localparam logic [15:0] ddpm_rst_ptr = 16'h0000;
    // second circular region base
    localparam logic [15:0] ddpm_region_b = 16'h0100;
    // extension opcodes (second byte after prefix)
    localparam logic [7:0] ddpm_prefix = 8'ha5;
    localparam logic [7:0] ddpm_op_mov_alt = 8'h90;
    localparam logic [7:0] ddpm_op_movc_alt = 8'h93;
    localparam logic [7:0] ddpm_op_inc_alt = 8'ha3;
    localparam logic [7:0] ddpm_op_rd_alt = 8'he0;
    localparam logic [7:0] ddpm_op_wr_alt = 8'hf0;
    // cycle counts of the extension opcodes
    localparam logic [2:0] ddpm_cyc_mov_alt = 3'h4;
    localparam logic [2:0] ddpm_cyc_movc_alt = 3'h4;
    localparam logic [2:0] ddpm_cyc_inc_alt = 3'h3;
    localparam logic [2:0] ddpm_cyc_movx_fast = 3'h3;
    localparam logic [2:0] ddpm_cyc_movx_slow = 3'h5;
    // access kinds issued by the decoder
    typedef enum logic [2:0] {
        ddpm_acc_none,
        ddpm_acc_movx_rd,
        ddpm_acc_movx_wr,
        ddpm_acc_movc,
        ddpm_acc_inc,
        ddpm_acc_load
    } ddpm_acc_t;
endpackage : ddpm_pkg
`default_nettype wire

// ---- rtl/ddpm_step_if.sv ----
// carrier between the pointer top and its circular step units
// assumes both ends on pclk
`timescale 1ns/1ns
`default_nettype none
interface ddpm_step_if;
    logic [15:0] cur;
    logic down;
    logic circ;
    logic [7:0] last;
    logic [15:0] nxt;
    modport user (output cur, output down, output circ, output last,
        input nxt);
    modport unit (input cur, input down, input circ, input last,
        output nxt);
endinterface : ddpm_step_if
`default_nettype wire

// ---- rtl/ddpm_step.sv ----
// circular-aware plus or minus one step of a 16-bit pointer
// assumes purely combinational use inside pclk logic
`timescale 1ns/1ns
`default_nettype none
module ddpm_step
    import ddpm_pkg::*;
(
    ddpm_step_if.unit s
);
    logic [15:0] top_a;
    logic [15:0] top_b;
    assign top_a = {8'h00, s.last};
    assign top_b = ddpm_region_b + {8'h00, s.last};
    always_comb begin
        s.nxt = s.down ? s.cur - 16'h0001 : s.cur + 16'h0001;
        if (s.circ) begin
            if (!s.down && s.cur == top_a) begin
                s.nxt = 16'h0000;
            end else if (!s.down && s.cur == top_b) begin
                s.nxt = ddpm_region_b;
            end else if (s.down && s.cur == 16'h0000) begin
                s.nxt = top_a;
            end else if (s.down && s.cur == ddpm_region_b) begin
                s.nxt = top_b;
            end
        end
    end
endmodule : ddpm_step
`default_nettype wire

// ---- rtl/ddpm_top.sv ----
// dual data pointer mode block: pointers, modes, routing, extensions
// assumes the cpu decoder on pclk and apb access to the registers
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ddpm_top
    import ddpm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic acc_valid,
    input wire ddpm_pkg::ddpm_acc_t acc_kind,
    input wire logic acc_alt,
    input wire logic acc_ext,
    input wire logic acc_slow,
    input wire logic [7:0] acc_value,
    input wire logic [15:0] acc_imm,
    output logic addr_valid,
    output logic [15:0] addr_out,
    output logic addr_is_code,
    output logic addr_write,
    output logic data_to_b,
    output logic [2:0] cycle_count,
    output logic [15:0] pointer_zero_out,
    output logic [15:0] pointer_one_out
);
    import ddpm_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] cfg_q;
    logic [7:0] last_q;
    logic [15:0] dp0_q;
    logic [15:0] dp1_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic pready_q;

    logic wr_en;
    logic rd_en;
    logic hit;
    logic [31:0] rd_mux;

    assign wr_en = psel && penable && pwrite && pready_q;
    assign rd_en = psel && !penable;

    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            ddpm_off_mode: rd_mux = {24'h000000, mode_q};
            ddpm_off_cfg: rd_mux = {24'h000000, cfg_q};
            ddpm_off_dp0: rd_mux = {16'h0000, dp0_q};
            ddpm_off_dp1: rd_mux = {16'h0000, dp1_q};
            ddpm_off_last_w: rd_mux = {24'h000000, last_q};
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // apb slave: no wait states, read data latched in setup
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (rd_en) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= !hit;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= ddpm_rst_mode;
            cfg_q <= ddpm_rst_cfg;
        end else if (wr_en) begin
            if (paddr == ddpm_off_mode) begin
                mode_q <= {4'h0, pwdata[3:0]};
            end
            if (paddr == ddpm_off_cfg) begin
                cfg_q <= {pwdata[7:4], 3'h0, pwdata[0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= ddpm_rst_last;
        end else if (wr_en && paddr == ddpm_off_last_w) begin
            last_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // pointer selection
    // ------------------------------------------------------------
    logic sel;
    logic use_one;
    assign sel = cfg_q[ddpm_bit_sel];
    assign use_one = sel ^ acc_alt;

    ddpm_step_if s0 ();
    ddpm_step_if s1 ();

    // both regions shared by both pointers
    assign s0.cur = dp0_q;
    assign s0.circ = mode_q[ddpm_bit_circ0];
    assign s0.last = last_q;
    assign s1.cur = dp1_q;
    assign s1.circ = mode_q[ddpm_bit_circ1];
    assign s1.last = last_q;

    logic explicit_inc;
    assign explicit_inc = acc_kind == ddpm_acc_inc;
    // direction from update_down for both kinds of update
    assign s0.down = cfg_q[ddpm_bit_down0];
    assign s1.down = cfg_q[ddpm_bit_down1];

    ddpm_step u_step0 (.s(s0));
    ddpm_step u_step1 (.s(s1));

    logic is_xfer;
    logic upd0;
    logic upd1;
    assign is_xfer = acc_kind == ddpm_acc_movx_rd ||
        acc_kind == ddpm_acc_movx_wr || acc_kind == ddpm_acc_movc;
    assign upd0 = acc_valid && !use_one &&
        (explicit_inc || (is_xfer && cfg_q[ddpm_bit_upd0]));
    assign upd1 = acc_valid && use_one &&
        (explicit_inc || (is_xfer && cfg_q[ddpm_bit_upd1]));

    logic load0;
    logic load1;
    // immediate load into the selected pointer
    assign load0 = acc_valid && acc_kind == ddpm_acc_load && !use_one;
    assign load1 = acc_valid && acc_kind == ddpm_acc_load && use_one;

    logic wr_dp0;
    logic wr_dp1;
    assign wr_dp0 = wr_en && paddr == ddpm_off_dp0;
    assign wr_dp1 = wr_en && paddr == ddpm_off_dp1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp0_q <= ddpm_rst_ptr;
        end else if (load0) begin
            dp0_q <= acc_imm;
        end else if (upd0) begin
            dp0_q <= s0.nxt;
        end else if (wr_dp0) begin
            dp0_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dp1_q <= ddpm_rst_ptr;
        end else if (load1) begin
            dp1_q <= acc_imm;
        end else if (upd1) begin
            dp1_q <= s1.nxt;
        end else if (wr_dp1) begin
            dp1_q <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // address and routing outputs
    // ------------------------------------------------------------
    logic [15:0] base;
    logic [15:0] addr_d;
    logic to_b_d;
    logic index_on;
    logic [2:0] cyc_d;
    assign base = use_one ? dp1_q : dp0_q;
    // index dropped; extension keeps the index
    assign index_on = !mode_q[ddpm_bit_movcdis] || acc_ext;

    always_comb begin
        addr_d = base;
        if (acc_kind == ddpm_acc_movc && index_on) begin
            addr_d = base + {8'h00, acc_value};
        end
    end

    // redirect transfers of pointer one to B
    // extension moves always use the accumulator
    assign to_b_d = mode_q[ddpm_bit_redirect] && use_one && is_xfer &&
        !acc_ext;

    always_comb begin
        cyc_d = 3'h0;
        case (acc_kind)
            ddpm_acc_load: cyc_d = ddpm_cyc_mov_alt;
            ddpm_acc_movc: cyc_d = ddpm_cyc_movc_alt;
            ddpm_acc_inc: cyc_d = ddpm_cyc_inc_alt;
            ddpm_acc_movx_rd,
            ddpm_acc_movx_wr: cyc_d = acc_slow ? ddpm_cyc_movx_slow :
                ddpm_cyc_movx_fast;
            default: cyc_d = 3'h0;
        endcase
        if (!acc_ext) begin
            cyc_d = 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_valid <= 1'b0;
            addr_out <= 16'h0000;
            addr_is_code <= 1'b0;
            addr_write <= 1'b0;
            data_to_b <= 1'b0;
            cycle_count <= 3'h0;
        end else begin
            addr_valid <= acc_valid && is_xfer;
            addr_out <= addr_d;
            addr_is_code <= acc_kind == ddpm_acc_movc;
            addr_write <= acc_kind == ddpm_acc_movx_wr;
            data_to_b <= acc_valid && to_b_d;
            cycle_count <= acc_valid ? cyc_d : 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pointer_zero_out <= ddpm_rst_ptr;
            pointer_one_out <= ddpm_rst_ptr;
        end else begin
            pointer_zero_out <= dp0_q;
            pointer_one_out <= dp1_q;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence inc_at_top_a;
        acc_valid && acc_kind == ddpm_acc_inc && !use_one &&
            mode_q[ddpm_bit_circ0] && !cfg_q[ddpm_bit_down0] &&
            dp0_q == {8'h00, last_q} && !load0;
    endsequence

    a_wrap_inc_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        inc_at_top_a |=> dp0_q == 16'h0000)
        else $error("increment at top of region did not wrap");

    a_wrap_dec_b: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_valid && acc_kind == ddpm_acc_inc && use_one &&
        mode_q[ddpm_bit_circ1] && cfg_q[ddpm_bit_down1] &&
        dp1_q == ddpm_region_b
        |=> dp1_q == ddpm_region_b + {8'h00, $past(last_q)})
        else $error("decrement at second base did not wrap");

    a_redirect_b: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_valid && is_xfer && !acc_ext && use_one &&
        mode_q[ddpm_bit_redirect] |=> data_to_b)
        else $error("pointer one transfer not sent to b");

    a_no_redirect_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_valid && !use_one |=> !data_to_b)
        else $error("pointer zero transfer sent to b");

    a_index_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_valid && acc_kind == ddpm_acc_movc && !acc_ext &&
        mode_q[ddpm_bit_movcdis] |=> addr_out == $past(base))
        else $error("indexed fetch added accumulator");

    a_no_auto_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_valid && is_xfer && !use_one && !cfg_q[ddpm_bit_upd0] &&
        !wr_dp0 |=> $stable(dp0_q))
        else $error("pointer changed without auto update");

    a_alt_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_valid && acc_kind == ddpm_acc_movx_rd && acc_alt && !sel
        |=> addr_out == $past(dp1_q))
        else $error("alternate pointer not pointer one");

    a_inc_cycles: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_valid && acc_ext && acc_kind == ddpm_acc_inc
        |=> cycle_count == 3'h3)
        else $error("alternate increment cycle count wrong");

    a_last_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> last_q == 8'h00)
        else $error("limit register not zero after reset");
endmodule : ddpm_top
`default_nettype wire

// ---- tb/ddpm_dec_model.sv ----
// cpu decoder model: issues one access or operation per call
// assumes pclk from the bench and a released reset before the first call
`timescale 1ns/1ns
`default_nettype none
module ddpm_dec_model
    import ddpm_pkg::*;
(
    input wire logic pclk,
    output logic acc_valid,
    output ddpm_pkg::ddpm_acc_t acc_kind,
    output logic acc_alt,
    output logic acc_ext,
    output logic acc_slow,
    output logic [7:0] acc_value,
    output logic [15:0] acc_imm
);
    initial begin
        acc_valid = 1'b0;
        acc_kind = ddpm_acc_none;
        {acc_alt, acc_ext, acc_slow} = 3'h0;
        acc_value = 8'h00;
        acc_imm = 16'h0000;
    end

    // one-cycle request; operands flip when idle so stale values show
    task automatic issue(input ddpm_acc_t k, input logic alt, input logic ext,
        input logic slow, input logic [7:0] v, input logic [15:0] imm);
        @(posedge pclk);
        acc_valid <= 1'b1;
        acc_kind <= k;
        {acc_alt, acc_ext, acc_slow} <= {alt, ext, slow};
        acc_value <= v;
        acc_imm <= imm;
        @(posedge pclk);
        acc_valid <= 1'b0;
        acc_kind <= ddpm_acc_none;
        acc_value <= ~v;
        acc_imm <= ~imm;
    endtask : issue
endmodule : ddpm_dec_model
`default_nettype wire

// ---- tb/test_dual_data_pointer_modes.sv ----
// self-checking bench for the dual data pointer block
// assumes the decoder model beside the design and apb on pclk
`timescale 1ns/1ns
`default_nettype none
module test_dual_data_pointer_modes;
    import ddpm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [9:0] paddr;
    logic [7:0] v, last;
    logic [31:0] pwdata, prdata, r;
    logic acc_valid, acc_alt, acc_ext, acc_slow, seen;
    ddpm_acc_t acc_kind, k;
    logic [7:0] acc_value;
    logic [15:0] acc_imm, addr_out, p0, p1, pa, c, imm;
    logic [15:0] pointer_zero_out, pointer_one_out;
    logic addr_valid, addr_is_code, addr_write, data_to_b;
    logic one, dn, circ, upd, idx;
    logic [2:0] cycle_count;
    logic [23:0] oe;
    int fail_count = 0;
    int comparisons = 0;
    logic [32:0] rd_q[$];
    logic [23:0] op_q[$];

    ddpm_top i_ddpm_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_alt(acc_alt),
        .acc_ext(acc_ext), .acc_slow(acc_slow), .acc_value(acc_value),
        .acc_imm(acc_imm), .addr_valid(addr_valid), .addr_out(addr_out),
        .addr_is_code(addr_is_code), .addr_write(addr_write),
        .data_to_b(data_to_b), .cycle_count(cycle_count),
        .pointer_zero_out(pointer_zero_out),
        .pointer_one_out(pointer_one_out));
    ddpm_dec_model i_ddpm_dec_model (.pclk(pclk), .acc_valid(acc_valid),
        .acc_kind(acc_kind), .acc_alt(acc_alt), .acc_ext(acc_ext),
        .acc_slow(acc_slow), .acc_value(acc_value), .acc_imm(acc_imm));

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, rd_q.pop_front());
    end

    always @(posedge pclk) begin
        if (seen) begin
            oe = op_q.pop_front();
            if (oe[23])
                check({addr_valid, addr_out, addr_is_code, addr_write,
                    data_to_b, cycle_count}, oe[22:0]);
            else
                check(cycle_count, oe[2:0]);
        end
        seen <= acc_valid;
    end

    // ------------------------------------------------------------
    // apb master and decoder requests
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [9:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [9:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic op(input logic [23:0] e, input ddpm_acc_t kk,
        input logic [2:0] f, input logic [7:0] vv, input logic [15:0] i);
        op_q.push_back(e);
        i_ddpm_dec_model.issue(kk, f[2], f[1], f[0], vv, i);
    endtask : op

    function automatic logic [15:0] nxt(input logic [15:0] x,
        input logic d, input logic ce, input logic [7:0] l);
        if (ce && !d && x == {8'h00, l}) return 16'h0000;
        if (ce && !d && x == ddpm_region_b + {8'h00, l}) return ddpm_region_b;
        if (ce && d && x == 16'h0000) return {8'h00, l};
        if (ce && d && x == ddpm_region_b) return ddpm_region_b + {8'h00, l};
        return d ? x - 16'h0001 : x + 16'h0001;
    endfunction : nxt

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge pclk);
        fail_count++;
        end_sim();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, seen} = 4'h0;
        paddr = 10'h000;
        pwdata = 32'h0;
        r = $urandom(77);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(ddpm_off_mode, 33'h0);
        rd(ddpm_off_cfg, 33'h0);
        rd(ddpm_off_dp0, 33'h0);
        rd(ddpm_off_dp1, 33'h0);
        rd(ddpm_off_last_w, 33'h0);
        rd(10'h040, {1'b1, 32'h0});
        last = 8'($urandom);
        apb(1'b1, ddpm_off_last_w, {24'h0, last});
        rd(ddpm_off_last_w, {25'h0, last});
        // routing: redirect, index off, select, alternate, movc or movx
        for (int m = 0; m < 32; m++) begin
            p0 = 16'($urandom);
            p1 = 16'($urandom);
            v = 8'($urandom);
            apb(1'b1, ddpm_off_mode, 32'(m[1:0]));
            apb(1'b1, ddpm_off_cfg, 32'(m[2]));
            apb(1'b1, ddpm_off_dp0, {16'h0, p0});
            apb(1'b1, ddpm_off_dp1, {16'h0, p1});
            one = m[2] ^ m[3];
            pa = one ? p1 : p0;
            if (m[4]) begin
                k = ddpm_acc_movc;
                pa = m[1] ? pa : pa + {8'h00, v};
            end else
                k = m[1] ? ddpm_acc_movx_wr : ddpm_acc_movx_rd;
            op({2'b11, pa, m[4], !m[4] && m[1], m[0] && one, 3'h0}, k,
                {m[3], 2'b00}, v, 16'h0);
        end
        // circular stepping with the other pointer's enable opposite
        for (int i = 0; i < 64; i++) begin
            r = $urandom;
            // boundary cases force circular mode so every wrap is reached
            {idx, dn, circ, upd} = {i[4], i[5], r[2] | r[3] | !i[2],
                r[5] | r[6]};
            case (i[2:0])
                3'h0: c = 16'h0000;
                3'h1: c = {8'h00, last};
                3'h2: c = ddpm_region_b;
                3'h3: c = ddpm_region_b + {8'h00, last};
                3'h4: c = {8'h00, last} + 16'h0001;
                default: c = r[31:16];
            endcase
            apb(1'b1, ddpm_off_mode,
                {28'h0, idx ? {circ, !circ} : {!circ, circ}, 2'b00});
            apb(1'b1, ddpm_off_cfg,
                {24'h0, upd & idx, upd & !idx, dn & idx, dn & !idx, 3'h0, idx});
            apb(1'b1, idx ? ddpm_off_dp1 : ddpm_off_dp0, {16'h0, c});
            if (i[3])
                op(24'h0, ddpm_acc_inc, 3'h0, 8'h00, 16'h0);
            else
                op({2'b11, c, 5'h0}, ddpm_acc_movx_rd, 3'h0, 8'h00,
                    16'h0);
            pa = (upd || i[3]) ? nxt(c, dn, circ, last) : c;
            rd(idx ? ddpm_off_dp1 : ddpm_off_dp0,
                {17'h0, pa});
        end
        // prefixed extensions on the alternate pointer, redirect left on
        apb(1'b1, ddpm_off_mode, 32'h1);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, ddpm_off_cfg, 32'(s));
            imm = 16'($urandom);
            v = 8'($urandom);
            op({21'h0, 3'h4}, ddpm_acc_load, 3'h6, 8'h00, imm);
            op({2'b11, imm + {8'h00, v}, 3'h4, 3'h4}, ddpm_acc_movc, 3'h6, v,
                16'h0);
            op({21'h0, 3'h3}, ddpm_acc_inc, 3'h6, 8'h00, 16'h0);
            op({2'b11, imm + 16'h1, 5'h3}, ddpm_acc_movx_rd, 3'h6, 8'h00,
                16'h0);
            op({2'b11, imm + 16'h1, 5'h0d}, ddpm_acc_movx_wr, 3'h7, 8'h00,
                16'h0);
            rd(s ? ddpm_off_dp0 : ddpm_off_dp1, {17'h0, imm + 16'h1});
            if (s)
                p0 = imm + 16'h1;
            else
                p1 = imm + 16'h1;
        end
        repeat (4) @(posedge pclk);
        check({pointer_zero_out, pointer_one_out}, {p0, p1});
        end_sim();
    end
endmodule : test_dual_data_pointer_modes
`default_nettype wire
